// >>> design/osc_pkg.sv
/*
 * Package for the internal oscillator select and tune block: register offsets,
 * field positions, reset values, source frequencies and timing constants.
 * Assumes a 40 MHz APB clock from which all oscillator rates are synthesised.
 */
package osc_pkg;
   localparam logic [7:0] ADDR_TUNING = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_CONTROL2 = 8'h08;
   localparam logic [7:0] ADDR_CONFIG = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   localparam int TUNE_LSB = 0;
   localparam int MULT_EN_BIT = 6;
   localparam int LOW_SRC_BIT = 7;
   localparam int SYS_SEL_LSB = 0;
   localparam int RATE_LSB = 4;
   localparam int SUBST_BIT = 4;
   localparam int CFG_LSB = 0;
   localparam int FUSE_BIT = 4;

   localparam logic [7:0] TUNING_RESET = 8'h00;
   localparam logic [2:0] RATE_RESET = 3'h3;
   localparam logic [1:0] SYS_SEL_RESET = 2'h0;
   localparam logic [3:0] CFG_RESET = 4'h8;

   localparam logic [1:0] SYS_SEL_INTERNAL = 2'h2;
   localparam logic [1:0] SYS_SEL_PRIMARY = 2'h0;
   localparam logic [2:0] CFG_INTERNAL_HI = 3'h4;
   localparam logic [3:0] CFG_INT_IO = 4'h8;
   localparam logic [3:0] CFG_INT_QUARTER_RATE_CLOCK_OUT = 4'h9;

   localparam int CLK_HZ = 40000000;
   localparam int HF_HZ = 16000000;
   localparam int MF_HZ = 500000;
   localparam int LF_HZ = 31250;
   localparam int ACC_W = 25;
   // One full accumulator turn is one source period, so the top bit rises once per period
   localparam longint ACC_ONE = 64'd1 << ACC_W;
   localparam logic [ACC_W-1:0] HF_INC = ACC_W'(ACC_ONE * HF_HZ / CLK_HZ);
   localparam logic [ACC_W-1:0] MF_INC = ACC_W'(ACC_ONE * MF_HZ / CLK_HZ);
   localparam logic [ACC_W-1:0] LF_INC = ACC_W'(ACC_ONE * LF_HZ / CLK_HZ);
   localparam logic [ACC_W-1:0] HF_STEP = HF_INC >> 7;
   localparam logic [ACC_W-1:0] MF_STEP = MF_INC >> 7;

   localparam int SLEW_NS = 1000;
   localparam int CLK_NS = 25;
   localparam int SLEW_CYCLES = SLEW_NS / CLK_NS;

   typedef struct packed {
      logic low_src;
      logic mult_en;
      logic [5:0] tuning;
      logic [2:0] rate;
      logic [1:0] sys_sel;
      logic subst;
      logic [3:0] cfg;
      logic fuse;
   } ctrl_type;
endpackage : osc_pkg

// >>> design/internal_osc_select_tune.sv
/*
 * Internal oscillator select and tune control: APB register file, digital
 * models of the three internal sources, divider/multiplexer with glitch-free
 * rate switching, multiplier gating and pin configuration outputs.
 * Assumes one 40 MHz clock and an APB master that waits on pready.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
// Functional notes
// - High source runs at nominal 16 MHz, tuned by the tuning code.
// - Medium source runs at nominal 500 kHz, tuned by the same code.
// - Low source runs at 31.25 kHz and ignores the tuning code.
// - Tuning code is 6-bit two's complement, reset to zero (calibrated).
// - Positive codes raise, negative codes lower; most negative gives minimum.
// - Frequency slews gradually after a tuning write; no completion flag.
// - Low source clocks power-up timer, watchdog and fail-safe monitor.
// - Bit 7 picks lowest rate from divided medium/high or low source.
// - In internal primary modes, multiplier enable acts only with rate 11x; else reads zero.
// - Eight selectable rates, 16 MHz down to 31 kHz; reset selects 1 MHz.
// - High and medium outputs are divided and multiplexed with low output.
// - 500/250 kHz from medium or high; 31 kHz from low, medium or high.
// - Two internal primary modes free input pin; output pin is I/O or clock/4.
// - External modes enable multiplier if fuse bit or enable bit is set.
// - Multiplier gives four times input, 4 to 16 MHz inputs, up to 64 MHz.
// - Internal high source with multiplier enabled gives up to 64 MHz.
// - System clock select 10 takes the internal block rate.
`timescale 1ns/100ps
module internal_osc_select_tune
   import osc_pkg::*;
#(
   parameter int SLEW_CYC = SLEW_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock enables
   output logic internal_clock_output,
   output logic low_freq_tick,
   output logic sys_clk_tick,
   // Multiplier and pins
   output logic multiplier_on,
   output logic osc_input_pin_is_io,
   output logic osc_output_pin_is_io,
   output logic quarter_rate_clock_out
);
   ctrl_type ctrl_r;
   logic [5:0] applied_r;
   logic [$clog2(SLEW_CYC+1)-1:0] slew_cnt_r;
   logic [ACC_W-1:0] hf_acc_r, mf_acc_r, lf_acc_r;
   logic [ACC_W-1:0] hf_inc, mf_inc;
   logic hf_msb_r, mf_msb_r, lf_msb_r;
   logic hf_tick, mf_tick, lf_tick;
   logic [8:0] hf_div_r;
   logic [3:0] mf_div_r;
   logic [2:0] act_rate_r;
   logic act_subst_r, act_low_r;
   logic int_tick;
   logic internal_primary, mult_avail, mult_nxt;
   logic [1:0] q_cnt_r;
   logic wr_en, rd_phase;
   logic [31:0] rd_nxt;
   logic hit;

   // APB: one wait state, data and answer registered
   assign rd_phase = psel && penable && !pready;
   assign wr_en = psel && penable && pready && pwrite;
   assign hit = paddr inside {ADDR_TUNING, ADDR_CONTROL, ADDR_CONTROL2, ADDR_CONFIG, ADDR_STATUS};

   assign internal_primary = ctrl_r.cfg[3:1] == CFG_INTERNAL_HI;
   assign mult_avail = internal_primary && ctrl_r.rate[2:1] == 2'b11;
   assign mult_nxt = internal_primary ? (mult_avail && ctrl_r.mult_en)
                                      : (ctrl_r.fuse || ctrl_r.mult_en);

   always_comb begin
      rd_nxt = 32'h0;
      unique case (paddr)
         ADDR_TUNING: begin
            rd_nxt[TUNE_LSB +: 6] = ctrl_r.tuning;
            rd_nxt[MULT_EN_BIT] = ctrl_r.mult_en && (mult_avail || !internal_primary);
            rd_nxt[LOW_SRC_BIT] = ctrl_r.low_src;
         end
         ADDR_CONTROL: begin
            rd_nxt[SYS_SEL_LSB +: 2] = ctrl_r.sys_sel;
            rd_nxt[RATE_LSB +: 3] = ctrl_r.rate;
         end
         ADDR_CONTROL2: rd_nxt[SUBST_BIT] = ctrl_r.subst;
         ADDR_CONFIG: begin
            rd_nxt[CFG_LSB +: 4] = ctrl_r.cfg;
            rd_nxt[FUSE_BIT] = ctrl_r.fuse;
         end
         ADDR_STATUS: begin
            rd_nxt[0] = multiplier_on;
            rd_nxt[3:1] = act_rate_r;
         end
         default: rd_nxt = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= rd_phase;
         pslverr <= rd_phase && !hit;
         if (rd_phase) begin
            prdata <= rd_nxt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r.low_src <= TUNING_RESET[LOW_SRC_BIT];
         ctrl_r.mult_en <= TUNING_RESET[MULT_EN_BIT];
         ctrl_r.tuning <= TUNING_RESET[TUNE_LSB +: 6];
         ctrl_r.rate <= RATE_RESET;
         ctrl_r.sys_sel <= SYS_SEL_RESET;
         ctrl_r.subst <= 1'b0;
         ctrl_r.cfg <= CFG_RESET;
         ctrl_r.fuse <= 1'b0;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_TUNING: begin
               ctrl_r.tuning <= pwdata[TUNE_LSB +: 6];
               ctrl_r.mult_en <= pwdata[MULT_EN_BIT];
               ctrl_r.low_src <= pwdata[LOW_SRC_BIT];
            end
            ADDR_CONTROL: begin
               ctrl_r.sys_sel <= pwdata[SYS_SEL_LSB +: 2];
               ctrl_r.rate <= pwdata[RATE_LSB +: 3];
            end
            ADDR_CONTROL2: ctrl_r.subst <= pwdata[SUBST_BIT];
            ADDR_CONFIG: begin
               ctrl_r.cfg <= pwdata[CFG_LSB +: 4];
               ctrl_r.fuse <= pwdata[FUSE_BIT];
            end
            default: ;
         endcase
      end
   end

   // Applied tuning walks one step per slew period toward the written code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         applied_r <= 6'h00;
         slew_cnt_r <= '0;
      end else if (applied_r == ctrl_r.tuning) begin
         slew_cnt_r <= '0;
      end else if (slew_cnt_r == ($bits(slew_cnt_r))'(SLEW_CYC - 1)) begin
         slew_cnt_r <= '0;
         if ($signed(applied_r) < $signed(ctrl_r.tuning)) begin
            applied_r <= applied_r + 6'h01;
         end else begin
            applied_r <= applied_r - 6'h01;
         end
      end else begin
         slew_cnt_r <= slew_cnt_r + 1'b1;
      end
   end

   // Signed step scaling: positive codes raise, negative lower
   assign hf_inc = HF_INC + ACC_W'($signed(applied_r) * $signed({1'b0, HF_STEP}));
   assign mf_inc = MF_INC + ACC_W'($signed(applied_r) * $signed({1'b0, MF_STEP}));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hf_acc_r <= '0;
         mf_acc_r <= '0;
         lf_acc_r <= '0;
         hf_msb_r <= 1'b0;
         mf_msb_r <= 1'b0;
         lf_msb_r <= 1'b0;
      end else begin
         hf_acc_r <= hf_acc_r + hf_inc;
         mf_acc_r <= mf_acc_r + mf_inc;
         lf_acc_r <= lf_acc_r + LF_INC;
         hf_msb_r <= hf_acc_r[ACC_W-1];
         mf_msb_r <= mf_acc_r[ACC_W-1];
         lf_msb_r <= lf_acc_r[ACC_W-1];
      end
   end

   assign hf_tick = hf_acc_r[ACC_W-1] && !hf_msb_r;
   assign mf_tick = mf_acc_r[ACC_W-1] && !mf_msb_r;
   assign lf_tick = lf_acc_r[ACC_W-1] && !lf_msb_r;

   // Dividers count source edges; a rate ticks when its low bits wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hf_div_r <= '0;
         mf_div_r <= '0;
      end else begin
         if (hf_tick) begin
            hf_div_r <= hf_div_r + 1'b1;
         end
         if (mf_tick) begin
            mf_div_r <= mf_div_r + 1'b1;
         end
      end
   end

   always_comb begin
      int_tick = 1'b0;
      unique case (act_rate_r)
         3'h7: int_tick = hf_tick;
         3'h6: int_tick = hf_tick && hf_div_r[0];
         3'h5: int_tick = hf_tick && &hf_div_r[1:0];
         3'h4: int_tick = hf_tick && &hf_div_r[2:0];
         3'h3: int_tick = hf_tick && &hf_div_r[3:0];
         3'h2: int_tick = act_subst_r ? mf_tick : hf_tick && &hf_div_r[4:0];
         3'h1: int_tick = act_subst_r ? mf_tick && mf_div_r[0] : hf_tick && &hf_div_r[5:0];
         3'h0: begin
            if (!act_low_r) begin
               int_tick = lf_tick;
            end else begin
               int_tick = act_subst_r ? mf_tick && &mf_div_r[3:0] : hf_tick && &hf_div_r[8:0];
            end
         end
      endcase
   end

   // New selection is taken only at an output tick, so no period is cut short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_rate_r <= RATE_RESET;
         act_subst_r <= 1'b0;
         act_low_r <= 1'b0;
      end else if (int_tick) begin
         act_rate_r <= ctrl_r.rate;
         act_subst_r <= ctrl_r.subst;
         act_low_r <= ctrl_r.low_src;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_clock_output <= 1'b0;
         low_freq_tick <= 1'b0;
         sys_clk_tick <= 1'b0;
         multiplier_on <= 1'b0;
      end else begin
         internal_clock_output <= int_tick;
         low_freq_tick <= lf_tick;
         sys_clk_tick <= int_tick && (ctrl_r.sys_sel == SYS_SEL_INTERNAL
                         || (ctrl_r.sys_sel == SYS_SEL_PRIMARY && internal_primary));
         multiplier_on <= mult_nxt;
      end
   end

   // Pin usage and clock/4 output in the internal primary modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_cnt_r <= 2'h0;
         osc_input_pin_is_io <= 1'b0;
         osc_output_pin_is_io <= 1'b0;
         quarter_rate_clock_out <= 1'b0;
      end else begin
         osc_input_pin_is_io <= internal_primary;
         osc_output_pin_is_io <= ctrl_r.cfg == CFG_INT_IO;
         if (ctrl_r.cfg != CFG_INT_QUARTER_RATE_CLOCK_OUT) begin
            q_cnt_r <= 2'h0;
            quarter_rate_clock_out <= 1'b0;
         end else if (int_tick) begin
            q_cnt_r <= q_cnt_r + 2'h1;
            if (q_cnt_r[0]) begin
               quarter_rate_clock_out <= !quarter_rate_clock_out;
            end
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   mult_gate_a: assert property (internal_primary && ctrl_r.rate[2:1] != 2'b11 |=> !multiplier_on)
      else $error("multiplier on outside 8/16 MHz internal");
   mult_ext_a: assert property (!internal_primary && (ctrl_r.fuse || ctrl_r.mult_en) |=> multiplier_on)
      else $error("external multiplier not enabled");
   low_tun_a: assert property ($changed(applied_r) |-> lf_acc_r - $past(lf_acc_r) == LF_INC)
      else $error("low source affected by tuning");
   slew_step_a: assert property ($changed(applied_r)
      |-> $past(slew_cnt_r) == ($bits(slew_cnt_r))'(SLEW_CYC - 1))
      else $error("tuning moved too fast");
   slew_dir_a: assert property ($changed(applied_r)
      && $signed($past(applied_r)) < $signed($past(ctrl_r.tuning))
      |-> applied_r == $past(applied_r) + 6'h01)
      else $error("tuning moved wrong way");
   sel_sync_a: assert property ($changed(act_rate_r) |-> $past(int_tick))
      else $error("rate switched away from tick");
   fast_rate_a: assert property (act_rate_r == 3'h7 && hf_tick |=> internal_clock_output)
      else $error("16 MHz rate not passed");
   low_src_a: assert property (act_rate_r == 3'h0 && !act_low_r && lf_tick |=> internal_clock_output)
      else $error("31 kHz not from low source");
   io_pin_a: assert property (ctrl_r.cfg == CFG_INT_IO |=> osc_output_pin_is_io && osc_input_pin_is_io)
      else $error("pin not freed");
   sys_sel_a: assert property (ctrl_r.sys_sel == SYS_SEL_INTERNAL && int_tick |=> sys_clk_tick)
      else $error("system clock not internal");

   rate_switch_c: cover property ($changed(act_rate_r));
   mult_int_c: cover property (internal_primary && multiplier_on);
   tune_min_c: cover property (applied_r == 6'h20);
   quarter_rate_clock_out_c: cover property ($rose(quarter_rate_clock_out));
endmodule : internal_osc_select_tune

// >>> dv/internal_osc_select_tune_bench.sv
/*
 * Self-checking bench for the internal oscillator select and tune block:
 * register rows, reset values, rate table, tuning, multiplier and pin modes.
 * Assumes the APB slave answers with pready and that the design holds its own checks.
 */
`timescale 1ns/100ps
module internal_osc_select_tune_bench
   import osc_pkg::*;
;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wd;
      logic [31:0] rd;
      logic err;
   } row_type;
   logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic ico, lft, sct, mult_on, in_io, out_io, qclk, rerr;
   int failures = 0;
   int check_count = 0;
   int n_ico, n_sys, n_low, n_q;
   row_type rows [8];
   int lo_tab [8] = '{1, 11, 23, 48, 98, 198, 398, 798};
   int hi_tab [8] = '{2, 14, 27, 52, 102, 202, 402, 802};
   logic [7:0] raddr [4] = '{ADDR_TUNING, ADDR_CONTROL, ADDR_CONTROL2, ADDR_CONFIG};
   logic [31:0] rval [4] = '{32'h00, 32'h30, 32'h00, 32'h08};

   internal_osc_select_tune #(.SLEW_CYC(2)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .internal_clock_output(ico), .low_freq_tick(lft), .sys_clk_tick(sct),
      .multiplier_on(mult_on), .osc_input_pin_is_io(in_io), .osc_output_pin_is_io(out_io),
      .quarter_rate_clock_out(qclk)
   );

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic check_range(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         failures++;
         $display("BAD t=%0t count %h range %h..%h", $time, got, lo, hi);
      end
   endtask : check_range

   // One APB transfer; waits on pready under a bound
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         failures++;
         end_of_test();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Counts output pulses and clock-out toggles over n cycles
   task automatic count(input int n);
      logic q_last;
      n_ico = 0;
      n_sys = 0;
      n_low = 0;
      n_q = 0;
      q_last = qclk;
      repeat (n) begin
         @(posedge pclk);
         if (ico === 1'b1) n_ico++;
         if (sct === 1'b1) n_sys++;
         if (lft === 1'b1) n_low++;
         if (qclk !== q_last) n_q++;
         q_last = qclk;
      end
   endtask : count

   initial begin
      rows[0] = '{ADDR_TUNING, 32'h9f, 32'h9f, 1'b0};
      rows[1] = '{ADDR_TUNING, 32'hff, 32'hbf, 1'b0};
      rows[2] = '{ADDR_CONTROL, 32'hffffff72, 32'h72, 1'b0};
      rows[3] = '{ADDR_TUNING, 32'h40, 32'h40, 1'b0};
      rows[4] = '{ADDR_CONTROL2, 32'h10, 32'h10, 1'b0};
      rows[5] = '{ADDR_CONFIG, 32'h19, 32'h19, 1'b0};
      rows[6] = '{8'h14, 32'h55, 32'h00, 1'b1};
      rows[7] = '{ADDR_CONFIG, 32'h08, 32'h08, 1'b0};
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      check({pready, mult_on, ico, sct}, 4'h0);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      check({in_io, out_io}, 2'h3);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, raddr[i], 32'h0);
         check(rdata, rval[i]);
      end
      count(2000);
      check_range(n_ico, lo_tab[3], hi_tab[3]);
      // Register rows: write, then read back
      foreach (rows[i]) begin
         apb(1'b1, rows[i].addr, rows[i].wd);
         check(rerr, rows[i].err);
         apb(1'b0, rows[i].addr, 32'h0);
         check({rerr, rdata}, {rows[i].err, rows[i].rd});
      end
      apb(1'b1, ADDR_CONTROL2, 32'h0);
      apb(1'b1, ADDR_TUNING, 32'h0);
      // Every rate, system clock on the internal block
      for (int r = 7; r >= 0; r--) begin
         apb(1'b1, ADDR_CONTROL, (r << 4) | 32'h2);
         count(200);
         count(2000);
         check_range(n_ico, lo_tab[r], hi_tab[r]);
         check(n_sys, n_ico);
      end
      // Medium source substitutes at 500 kHz
      apb(1'b1, ADDR_CONTROL2, 32'h10);
      apb(1'b1, ADDR_CONTROL, 32'h22);
      // Old 31 kHz rate may hold the switch off for a whole low-source period
      count(1400);
      count(2000);
      check_range(n_ico, lo_tab[2], hi_tab[2]);
      apb(1'b1, ADDR_CONTROL2, 32'h0);
      // Tuning extremes at 16 MHz
      apb(1'b1, ADDR_CONTROL, 32'h72);
      apb(1'b1, ADDR_TUNING, 32'h1f);
      count(300);
      count(2000);
      check_range(n_ico, 990, 997);
      apb(1'b1, ADDR_TUNING, 32'h20);
      count(300);
      count(2000);
      check_range(n_ico, 597, 603);
      // Lowest rate: direct low source ignores tuning, divided source follows it
      apb(1'b1, ADDR_TUNING, 32'h1f);
      apb(1'b1, ADDR_CONTROL, 32'h02);
      count(1400);
      count(12800);
      check_range(n_ico, 9, 11);
      check_range(n_low, 9, 11);
      apb(1'b1, ADDR_TUNING, 32'h9f);
      count(1400);
      count(12800);
      check_range(n_ico, 12, 13);
      check_range(n_low, 9, 11);
      // Multiplier gating, internal then external modes
      apb(1'b1, ADDR_TUNING, 32'h40);
      apb(1'b1, ADDR_CONTROL, 32'h32);
      count(4);
      check(mult_on, 1'b0);
      apb(1'b1, ADDR_CONTROL, 32'h62);
      count(4);
      check(mult_on, 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rdata[0], 1'b1);
      apb(1'b1, ADDR_CONFIG, 32'h00);
      apb(1'b1, ADDR_CONTROL, 32'h32);
      count(4);
      check({mult_on, in_io, out_io}, 3'h4);
      apb(1'b1, ADDR_TUNING, 32'h00);
      count(4);
      check(mult_on, 1'b0);
      apb(1'b1, ADDR_CONFIG, 32'h10);
      count(4);
      check(mult_on, 1'b1);
      // Clock-out mode toggles every second tick at 16 MHz
      apb(1'b1, ADDR_CONFIG, 32'h09);
      apb(1'b1, ADDR_CONTROL, 32'h72);
      count(1400);
      count(2000);
      check({in_io, out_io}, 2'h2);
      check_range(n_q, 398, 402);
      // Reset in mid-run restores defaults
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      check(rdata, 32'h30);
      end_of_test();
   end
endmodule : internal_osc_select_tune_bench
